// >>> hw/lts_search_if.sv
// Lookup table search interface: search control, routing result and age stamp
`timescale 1ns/1ps
module lts_search_if
	import lts_pkg::*;
#(
	parameter int PORTS = 15
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	// Direct I/O port pins
	input  wire logic             dio_sel_n,
	input  wire logic             dio_rd_nwr,
	input  wire logic [7:0]       dio_addr,
	input  wire logic [7:0]       dio_wdata,
	output logic [7:0]            dio_rdata,
	output logic                  search_done_irq,
	// Table search engine
	output logic                  srch_req,
	output logic [2:0]            srch_cmd,
	output logic                  srch_port_mod,
	output logic                  srch_vlan_mod,
	output logic [3:0]            srch_port_code,
	input  wire logic             srch_done,
	input  wire logic             srch_found,
	input  wire logic             srch_node_mcast,
	input  wire logic             srch_no_block_flag,
	input  wire logic [PORTS-1:0] srch_port_vector,
	input  wire logic [15:0]      srch_ucast_result,
	input  wire logic [15:0]      srch_age_sec,
	// No-block receive FIFO
	input  wire logic             nbf_empty,
	input  wire logic [3:0]       nbf_tag,
	input  wire logic [3:0]       nbf_src_port,
	output logic                  nbf_pop,
	// Frame forwarding path
	input  wire logic [PORTS-1:0] receive_block_mask,
	input  wire logic [3:0]       frm_src_port,
	input  wire logic             frm_no_block_flag,
	input  wire logic [3:0]       frm_tag,
	output logic                  frm_forward,
	output logic                  frm_vlan_valid,
	output logic [3:0]            frm_vlan
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	lts_dio_if   acc ();
	lts_state_e  state;
	logic [15:0] routing_result;
	logic [15:0] node_age_stamp;
	logic [7:0]  search_control;
	logic        busy;
	logic        ctrl_wr;
	logic        cmd_ok;
	logic [7:0]  wr_cmd;
	logic        fifo_cmd;
	logic        engine_done;
	logic        fifo_done;
	logic        route_wr;

	// Count of set bits in a command field
	function automatic logic [2:0] bit_count(input logic [7:0] v);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {2'h0, v[i]};
		end
		return n;
	endfunction

	// Control value at completion: found flag on top, commands gone, modifiers kept
	function automatic logic [7:0] clear_cmds(input logic [7:0] ctrl, input logic found);
		return {found, ctrl[6:0] & ~CTRL_CMD_MASK[6:0]};
	endfunction

	// ----------------------------------------------------------------
	// Port synchroniser and forwarding gate
	// ----------------------------------------------------------------
	lts_dio_sync u_sync (
		.clk        (clk),
		.arst_n     (arst_n),
		.dio_sel_n  (dio_sel_n),
		.dio_rd_nwr (dio_rd_nwr),
		.dio_addr   (dio_addr),
		.dio_wdata  (dio_wdata),
		.acc        (acc.port)
	);

	lts_fwd_gate #(
		.PORTS (PORTS)
	) u_fwd (
		.receive_block_mask (receive_block_mask),
		.frm_src_port       (frm_src_port),
		.frm_no_block_flag  (frm_no_block_flag),
		.frm_tag            (frm_tag),
		.frm_forward        (frm_forward),
		.frm_vlan_valid     (frm_vlan_valid),
		.frm_vlan           (frm_vlan)
	);

	// ----------------------------------------------------------------
	// Write decode
	// ----------------------------------------------------------------
	// Busy while any command bit stands
	assign busy     = (search_control & CTRL_CMD_MASK) != 8'h00;
	assign ctrl_wr  = acc.wr_stb & (acc.addr == CTRL_ADDR) & ~busy;
	assign wr_cmd   = acc.wdata & CTRL_CMD_MASK;
	// More than one command bit kills the whole write
	assign cmd_ok   = bit_count(wr_cmd) <= 3'h1;
	assign fifo_cmd = search_control[CTRL_FIFO_BIT];
	assign engine_done = (state == LTS_ENGINE) & srch_done;
	assign fifo_done   = (state == LTS_FIFO) & fifo_cmd;
	// Port code field is writable only while no search runs
	assign route_wr    = acc.wr_stb & (acc.addr == ROUTE_HI_ADDR) & ~busy;

	// ----------------------------------------------------------------
	// Search sequencer
	// ----------------------------------------------------------------
	// Idle until a single command is written, then run it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= LTS_IDLE;
		end else begin
			case (state)
				LTS_IDLE: begin
					if (ctrl_wr && cmd_ok && wr_cmd != 8'h00) begin
						state <= wr_cmd[CTRL_FIFO_BIT] ? LTS_FIFO : LTS_ENGINE;
					end
				end
				LTS_ENGINE: begin
					if (srch_done) begin
						state <= LTS_IDLE;
					end
				end
				LTS_FIFO: begin
					state <= LTS_IDLE;
				end
				default: begin
					state <= LTS_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Search engine request
	// ----------------------------------------------------------------
	// Request stands for the whole engine search
	assign srch_req = (state == LTS_ENGINE);
	// Command code: 0 exact, 1 next, 2 first, 3 new
	always_comb begin
		if (search_control[CTRL_NEW_BIT]) begin
			srch_cmd = 3'h3;
		end else if (search_control[CTRL_FIRST_BIT]) begin
			srch_cmd = 3'h2;
		end else if (search_control[CTRL_NEXT_BIT]) begin
			srch_cmd = 3'h1;
		end else begin
			srch_cmd = 3'h0;
		end
	end
	// Modifiers apply to first, next and new, alone or together
	assign srch_port_mod  = search_control[CTRL_PORT_BIT] & ~search_control[CTRL_EXACT_BIT];
	assign srch_vlan_mod  = search_control[CTRL_VLAN_BIT] & ~search_control[CTRL_EXACT_BIT];
	assign srch_port_code = routing_result[ROUTE_PCODE_LSB +: 4];
	// Pop the FIFO top when a FIFO read finds an entry
	assign nbf_pop = fifo_done & ~nbf_empty;

	// ----------------------------------------------------------------
	// Search control register
	// ----------------------------------------------------------------
	// Commands stand while running and clear on completion
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			search_control <= CTRL_RESET;
		end else if (engine_done) begin
			search_control <= clear_cmds(search_control, srch_found);
		end else if (fifo_done) begin
			search_control <= clear_cmds(search_control, ~nbf_empty);
		end else if (ctrl_wr && cmd_ok) begin
			// Found stays read-only; five commands and two modifiers are written
			search_control <= {search_control[CTRL_FOUND_BIT],
				acc.wdata[6:0] & (CTRL_CMD_MASK[6:0] | CTRL_MOD_MASK[6:0])};
		end
	end

	// ----------------------------------------------------------------
	// Routing result register
	// ----------------------------------------------------------------
	// Loaded from the engine or the FIFO; port code writable when idle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			routing_result <= ROUTE_RESET;
		end else if (engine_done && srch_found) begin
			if (srch_node_mcast) begin
				// Multicast: no-block in the top bit, one vector bit per port
				routing_result <= {srch_no_block_flag, 15'(srch_port_vector)};
			end else begin
				routing_result <= srch_ucast_result;
			end
		end else if (fifo_done && !nbf_empty) begin
			// FIFO entry: tag, source port, reserved low byte of zero
			routing_result <= {nbf_tag, nbf_src_port, 8'h00};
		end else if (route_wr) begin
			routing_result[ROUTE_PCODE_LSB +: 4] <= acc.wdata[3:0];
		end
	end

	// ----------------------------------------------------------------
	// Node age stamp register
	// ----------------------------------------------------------------
	// Seconds since the node was last seen, taken when an engine search finds the node
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			node_age_stamp <= AGE_RESET;
		end else if (engine_done && srch_found) begin
			node_age_stamp <= srch_age_sec;
		end
	end

	// ----------------------------------------------------------------
	// Completion pulse and read data
	// ----------------------------------------------------------------
	// One-cycle pulse as the command bits clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			search_done_irq <= 1'b0;
		end else begin
			search_done_irq <= engine_done | fifo_done;
		end
	end

	// Read data held in a flop after each read strobe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dio_rdata <= 8'h00;
		end else if (acc.rd_stb) begin
			case (acc.addr)
				ROUTE_LO_ADDR: dio_rdata <= routing_result[7:0];
				ROUTE_HI_ADDR: dio_rdata <= routing_result[15:8];
				AGE_LO_ADDR:   dio_rdata <= node_age_stamp[7:0];
				AGE_HI_ADDR:   dio_rdata <= node_age_stamp[15:8];
				CTRL_ADDR:     dio_rdata <= search_control;
				default:       dio_rdata <= 8'h00;
			endcase
		end
	end

endmodule // lts_search_if

// >>> hw/lts_pkg.sv
// Package with register map, field layout and states of the lookup search interface
package lts_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses on the direct I/O port
	// ----------------------------------------------------------------
	localparam logic [7:0] ROUTE_LO_ADDR = 8'h12;
	localparam logic [7:0] ROUTE_HI_ADDR = 8'h13;
	localparam logic [7:0] AGE_LO_ADDR   = 8'h14;
	localparam logic [7:0] AGE_HI_ADDR   = 8'h15;
	localparam logic [7:0] CTRL_ADDR     = 8'h16;

	// ----------------------------------------------------------------
	// Search control field positions
	// ----------------------------------------------------------------
	localparam int CTRL_EXACT_BIT = 0;
	localparam int CTRL_NEXT_BIT  = 1;
	localparam int CTRL_FIRST_BIT = 2;
	localparam int CTRL_VLAN_BIT  = 3;
	localparam int CTRL_PORT_BIT  = 4;
	localparam int CTRL_FIFO_BIT  = 5;
	localparam int CTRL_NEW_BIT   = 6;
	localparam int CTRL_FOUND_BIT = 7;
	localparam logic [7:0] CTRL_CMD_MASK = 8'h67;
	localparam logic [7:0] CTRL_MOD_MASK = 8'h18;

	// ----------------------------------------------------------------
	// Routing result field positions
	// ----------------------------------------------------------------
	localparam int ROUTE_NB_BIT     = 15;
	localparam int ROUTE_TAG_LSB    = 12;
	localparam int ROUTE_SRC_LSB    = 8;
	localparam int ROUTE_PCODE_LSB  = 8;
	localparam int NODE_MCAST_BIT   = 40;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] ROUTE_RESET = 16'h0000;
	localparam logic [15:0] AGE_RESET   = 16'h0000;
	localparam logic [7:0]  CTRL_RESET  = 8'h00;

	// Search engine state
	typedef enum logic [1:0] {
		LTS_IDLE   = 2'b00,
		LTS_ENGINE = 2'b01,
		LTS_FIFO   = 2'b10
	} lts_state_e;

endpackage

// >>> hw/lts_dio_if.sv
// Interface carrying synchronised management port accesses
`timescale 1ns/1ps
interface lts_dio_if;
	logic       rd_stb;	// One-cycle read strobe
	logic       wr_stb;	// One-cycle write strobe
	logic [7:0] addr;
	logic [7:0] wdata;

	modport port (output rd_stb, output wr_stb, output addr, output wdata);
	modport regs (input rd_stb, input wr_stb, input addr, input wdata);
endinterface

// >>> hw/lts_dio_sync.sv
// Pin synchroniser and strobe maker for the direct I/O port
`timescale 1ns/1ps
module lts_dio_sync (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       dio_sel_n,
	input  wire logic       dio_rd_nwr,
	input  wire logic [7:0] dio_addr,
	input  wire logic [7:0] dio_wdata,
	lts_dio_if.port         acc
);
	logic [17:0] meta;
	logic [17:0] sync;
	logic        sel_q;

	// Two flip-flops on every pin before use
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= 18'h3ffff;
			sync <= 18'h3ffff;
		end else begin
			meta <= {dio_sel_n, dio_rd_nwr, dio_addr, dio_wdata};
			sync <= meta;
		end
	end

	// Remember select so an access fires once per cycle of the port
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sel_q <= 1'b0;
		end else begin
			sel_q <= ~sync[17];
		end
	end

	// Strobes on the leading edge of select
	assign acc.rd_stb = ~sync[17] & ~sel_q & sync[16];
	assign acc.wr_stb = ~sync[17] & ~sel_q & ~sync[16];
	assign acc.addr   = sync[15:8];
	assign acc.wdata  = sync[7:0];
endmodule // lts_dio_sync

// >>> hw/lts_fwd_gate.sv
// Forwarding gate for no-block nodes and tag to VLAN mapping
`timescale 1ns/1ps
module lts_fwd_gate #(
	parameter int PORTS = 15
) (
	input  wire logic [PORTS-1:0] receive_block_mask,
	input  wire logic [3:0]       frm_src_port,
	input  wire logic             frm_no_block_flag,
	input  wire logic [3:0]       frm_tag,
	output logic                  frm_forward,
	output logic                  frm_vlan_valid,
	output logic [3:0]            frm_vlan
);
	logic blocked;

	// Originating port blocked for receive
	assign blocked = (int'(frm_src_port) < PORTS) ? receive_block_mask[frm_src_port] : 1'b0;
	// No-block node overrides the block, otherwise the block holds
	assign frm_forward = frm_no_block_flag | ~blocked;
	// Frames from port 0 take their VLAN from the decoded tag
	assign frm_vlan_valid = (frm_src_port == 4'h0);
	assign frm_vlan       = frm_tag;
endmodule // lts_fwd_gate

// >>> tb/lts_search_if_checker.sv
// Concurrent checks on the lookup search interface ports
`timescale 1ns/1ps
module lts_search_if_checker #(
	parameter int PORTS = 15
) (
	input wire logic             clk,
	input wire logic             arst_n,
	input wire logic             srch_req,
	input wire logic             srch_done,
	input wire logic [2:0]       srch_cmd,
	input wire logic             srch_port_mod,
	input wire logic             srch_vlan_mod,
	input wire logic             search_done_irq,
	input wire logic             nbf_pop,
	input wire logic             nbf_empty,
	input wire logic [PORTS-1:0] receive_block_mask,
	input wire logic [3:0]       frm_src_port,
	input wire logic             frm_no_block_flag,
	input wire logic [3:0]       frm_tag,
	input wire logic             frm_forward,
	input wire logic             frm_vlan_valid,
	input wire logic [3:0]       frm_vlan
);
	// ----------------------------------------------------------------
	// Search completion, modifier and forwarding relations
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// Completion: request gone with the pulse up, pulse gone one cycle later
	sequence s_finish;
		(!srch_req && search_done_irq) ##1 !search_done_irq;
	endsequence

	a_done_then_irq: assert property (srch_req && srch_done |=> s_finish)
		else $error("search end without completion pulse");
	a_req_held: assert property (srch_req && !srch_done |=> srch_req)
		else $error("search dropped before engine answer");
	a_irq_single: assert property (search_done_irq |=> !search_done_irq)
		else $error("completion pulse too long");
	a_pop_finish: assert property (nbf_pop |=> !nbf_pop && search_done_irq)
		else $error("fifo read did not complete");
	a_pop_nonempty: assert property (nbf_pop |-> !nbf_empty)
		else $error("pop from empty fifo");
	a_fwd_noblock: assert property (frm_no_block_flag |-> frm_forward)
		else $error("no-block frame held back");
	a_fwd_blocked: assert property (!frm_no_block_flag && frm_src_port < 4'hf
		|-> frm_forward == !receive_block_mask[frm_src_port])
		else $error("forward disagrees with block mask");
	a_vlan_port0: assert property (frm_vlan_valid == (frm_src_port == 4'h0)
		&& frm_vlan == frm_tag)
		else $error("tag vlan mapping wrong");
	a_exact_nomod: assert property (srch_req && srch_cmd == 3'h0
		|-> !srch_port_mod && !srch_vlan_mod)
		else $error("modifier sent with exact lookup");
endmodule // lts_search_if_checker

bind lts_search_if lts_search_if_checker #(.PORTS(PORTS)) lts_search_if_checker_i (.clk,
	.arst_n, .srch_req, .srch_done, .srch_cmd, .srch_port_mod, .srch_vlan_mod,
	.search_done_irq, .nbf_pop, .nbf_empty, .receive_block_mask, .frm_src_port,
	.frm_no_block_flag, .frm_tag, .frm_forward, .frm_vlan_valid, .frm_vlan);

// >>> tb/lts_engine_model.sv
// Table search engine stand-in with an adjustable answer delay
`timescale 1ns/1ps
module lts_engine_model (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       srch_req,
	input  wire logic [3:0] lat,	// Answer delay, at least 1
	output logic            srch_done
);
	logic [3:0] wait_cnt;

	// Count cycles of a running request
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wait_cnt <= 4'h0;
		end else if (srch_req && !srch_done) begin
			wait_cnt <= wait_cnt + 4'h1;
		end else begin
			wait_cnt <= 4'h0;
		end
	end

	// Answer once the delay has run out
	assign srch_done = srch_req && (wait_cnt == lat);
endmodule // lts_engine_model

// >>> tb/testbench.sv
// Self-checking testbench of the lookup search interface
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
	$display("wrong value %s expected %h seen %h", nm, exp, got); end end
module testbench
	import lts_pkg::*;
;
	logic        clk, arst_n, dio_sel_n, dio_rd_nwr, search_done_irq, srch_req, srch_done;
	logic        srch_port_mod, srch_vlan_mod, srch_found, srch_node_mcast, nbf_pop;
	logic        srch_no_block_flag, nbf_empty, frm_no_block_flag, frm_forward, frm_vlan_valid;
	logic [7:0]  dio_addr, dio_wdata, dio_rdata, rd;
	logic [2:0]  srch_cmd;
	logic [3:0]  srch_port_code, nbf_tag, nbf_src_port, frm_src_port, frm_tag, frm_vlan, lat;
	logic [14:0] srch_port_vector, receive_block_mask;
	logic [15:0] srch_ucast_result, srch_age_sec;
	int          err_total, tests_run;

	lts_search_if lts_search_if_i (.clk, .arst_n, .dio_sel_n, .dio_rd_nwr, .dio_addr,
		.dio_wdata, .dio_rdata, .search_done_irq, .srch_req, .srch_cmd, .srch_port_mod,
		.srch_vlan_mod, .srch_port_code, .srch_done, .srch_found, .srch_node_mcast,
		.srch_no_block_flag, .srch_port_vector, .srch_ucast_result, .srch_age_sec,
		.nbf_empty, .nbf_tag, .nbf_src_port, .nbf_pop, .receive_block_mask,
		.frm_src_port, .frm_no_block_flag, .frm_tag, .frm_forward, .frm_vlan_valid, .frm_vlan);
	lts_engine_model lts_engine_model_i (.clk, .arst_n, .srch_req, .lat, .srch_done);

	// 25 MHz clock
	always #20 clk = ~clk;

	// ----------------------------------------------------------------
	// Port access, polling and closing report
	// ----------------------------------------------------------------
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// One select-low access: 5 cycles low, 3 high, read data kept in rd
	task automatic acc(input logic rnw, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		dio_sel_n <= 1'b0;
		dio_rd_nwr <= rnw;
		dio_addr <= a;
		dio_wdata <= d;
		repeat (5) @(posedge clk);
		rd = dio_rdata;
		dio_sel_n <= 1'b1;
		repeat (3) @(posedge clk);
	endtask

	// Read control until its command bits clear, bounded
	task automatic poll;
		rd = 8'hff;
		for (int n = 0; n < 20 && (rd & CTRL_CMD_MASK) != 8'h00; n++) acc(1'b1, CTRL_ADDR, 8'h00);
		if ((rd & CTRL_CMD_MASK) !== 8'h00) begin
			err_total++;
			$display("wrong value poll expected 00 seen %h", rd);
			wrap_up;
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		logic [7:0] a[6] = '{ROUTE_LO_ADDR, ROUTE_HI_ADDR, AGE_LO_ADDR, AGE_HI_ADDR, CTRL_ADDR, 8'h20};
		foreach (a[i]) begin
			acc(1'b1, a[i], 8'h00);
			`CHK("reset value", 8'h00, rd)
		end
		$display("test reset done");
	endtask

	// Slow multicast search with a write attempt while locked
	task automatic t_mcast;
		lat <= 4'hf;
		srch_found <= 1'b1;
		srch_node_mcast <= 1'b1;
		srch_no_block_flag <= 1'b1;
		srch_port_vector <= 15'h4a53;
		srch_age_sec <= 16'h1234;
		acc(1'b0, CTRL_ADDR, 8'h04);
		`CHK("first request", 4'ha, {srch_req, srch_cmd})
		acc(1'b0, CTRL_ADDR, 8'h58);
		poll;
		`CHK("locked control", 8'h80, rd)
		acc(1'b1, ROUTE_LO_ADDR, 8'h00);
		`CHK("port vector low", 8'h53, rd)
		acc(1'b1, ROUTE_HI_ADDR, 8'h00);
		`CHK("no-block and vector", 8'hca, rd)
		acc(1'b1, AGE_LO_ADDR, 8'h00);
		`CHK("age low", 8'h34, rd)
		acc(1'b1, AGE_HI_ADDR, 8'h00);
		`CHK("age high", 8'h12, rd)
		$display("test multicast done");
	endtask

	// Every engine command with both modifiers, then a double command
	task automatic t_cmds;
		logic [7:0] c[4] = '{8'h01, 8'h02, 8'h04, 8'h40};
		logic [7:0] prev;
		srch_node_mcast <= 1'b0;
		srch_ucast_result <= 16'h9e00;
		foreach (c[i]) begin
			srch_found <= !i[0];
			acc(1'b0, CTRL_ADDR, c[i] | CTRL_MOD_MASK);
			`CHK("engine request", {1'b1, i[2:0], i != 0, i != 0}, {srch_req, srch_cmd, srch_port_mod, srch_vlan_mod})
			poll;
			`CHK("found flag", {!i[0], 7'h00}, rd & 8'he7)
		end
		prev = rd;
		acc(1'b0, CTRL_ADDR, 8'h06);
		`CHK("double command", 1'b0, srch_req)
		acc(1'b1, CTRL_ADDR, 8'h00);
		`CHK("control after double", prev, rd)
		acc(1'b1, ROUTE_HI_ADDR, 8'h00);
		`CHK("unicast result", 8'h9e, rd)
		$display("test commands done");
	endtask

	// No-block fifo read, reserved byte, then empty fifo
	task automatic t_fifo;
		nbf_empty <= 1'b0;
		nbf_tag <= 4'ha;
		nbf_src_port <= 4'h5;
		acc(1'b0, CTRL_ADDR, 8'h20);
		poll;
		`CHK("fifo found", 8'h80, rd & 8'he7)
		acc(1'b0, ROUTE_LO_ADDR, 8'hff);
		acc(1'b1, ROUTE_LO_ADDR, 8'h00);
		`CHK("reserved byte", 8'h00, rd)
		acc(1'b1, ROUTE_HI_ADDR, 8'h00);
		`CHK("tag and source", 8'ha5, rd)
		`CHK("port code", 4'h5, srch_port_code)
		nbf_empty <= 1'b1;
		acc(1'b0, CTRL_ADDR, 8'h20);
		poll;
		`CHK("fifo empty", 8'h00, rd & 8'he7)
		$display("test fifo done");
	endtask

	// Forwarding gate over all ports, no-block clear and set
	task automatic t_fwd;
		receive_block_mask <= 15'h5555;
		frm_tag <= 4'hc;
		for (int s = 0; s < 15; s++) for (int n = 0; n < 2; n++) begin
			@(posedge clk);
			frm_src_port <= s[3:0];
			frm_no_block_flag <= n[0];
			@(negedge clk);
			`CHK("forward", n[0] | s[0], frm_forward)
			`CHK("port zero vlan", {s == 0, 4'hc}, {frm_vlan_valid, frm_vlan})
		end
		$display("test forwarding done");
	endtask

	// Main sequence
	initial begin
		{clk, arst_n, dio_rd_nwr, dio_addr, dio_wdata, srch_found, srch_node_mcast} = '0;
		{srch_no_block_flag, srch_port_vector, srch_ucast_result, srch_age_sec} = '0;
		{nbf_tag, nbf_src_port, receive_block_mask, frm_src_port, frm_no_block_flag} = '0;
		{frm_tag, err_total, tests_run} = '0;
		dio_sel_n = 1'b1;
		nbf_empty = 1'b1;
		lat = 4'h1;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		t_reset;
		t_mcast;
		t_cmds;
		t_fifo;
		t_fwd;
		wrap_up;
	end
endmodule // testbench
